// *** test_watchdog_interval_timer.sv ***
/*
  test_watchdog_interval_timer: register-level tests of wdt_top.
  Assumes the checker is bound in and the system model stands beside.
*/
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_interval_timer;
  import wdt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic wake_nmi;
  logic overflow_out_n;
  logic chip_reset;
  logic chip_reset_manual;
  logic interval_irq;
  logic standby_active;
  logic clr = 1'b0;
  logic wake_req = 1'b0;
  logic [9:0] ovf_len;
  logic [9:0] rst_len;
  logic saw_manual;
  logic [1:0] resp;
  logic [31:0] rd;
  int fail_count = 0;
  int checked = 0;
  int dv[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  logic [7:0] rc[3] = '{8'h7f, 8'h5f, 8'h1f};
  int rl[3] = '{512, 512, 0};
  wdt_top dut (.*);
  wdt_sys_model sys (.aclk(aclk), .clr(clr), .wake_req(wake_req),
    .overflow_out_n(overflow_out_n), .chip_reset(chip_reset),
    .chip_reset_manual(chip_reset_manual), .standby_active(standby_active),
    .wake_nmi(wake_nmi), .ovf_len(ovf_len), .rst_len(rst_len), .saw_manual(saw_manual));
  // 100 MHz clock
  initial begin
    forever #5 aclk = ~aclk;
  end
  // ****
  // tasks
  // ****
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task hang;
    fail_count++;
    $display("BAD %0t wait ran out", $time);
    print_verdict();
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // an edge first, so back-to-back calls never assign a signal twice
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  // sel 0: pin low, 1: interrupt, 2: standby over
  task wfor(input int sel, input int mx);
    for (int n = 0; n < mx; n++) begin
      @(posedge aclk);
      if (sel == 0 ? !overflow_out_n : sel == 1 ? interval_irq : !standby_active) return;
    end
    hang();
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    cyc(20);
    aresetn <= 1'b1;
    rdr(ADDR_CTRL);
    chk(rd, 32'h18);
    rdr(ADDR_RST);
    chk(rd, 32'h1f);
    // only the low address nibble decodes, so offset 0x2 is the unmapped probe
    rdr(8'h02);
    chk(resp, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(ADDR_CNT, 16'h0012);
    chk(resp, RESP_SLVERR);
    wr(ADDR_CNT, 16'h5a12);
    chk(resp, RESP_OKAY);
    rdr(ADDR_CNT);
    chk(rd, 32'h0);
    $display("register access done");
    wr(ADDR_CTRL, 16'ha538);
    wfor(1, 700);
    rdr(ADDR_CTRL);
    chk(rd, 32'hb8);
    wr(ADDR_CTRL, 16'ha518);
    chk(interval_irq, 1'b0);
    $display("interval mode done");
    for (int p = 1; p < 8; p++) begin
      wr(ADDR_CTRL, {8'ha5, 5'h03, p[2:0]});
      wr(ADDR_CTRL, {8'ha5, 5'h07, p[2:0]});
      cyc(dv[p] * 3 + dv[p] / 2);
      rdr(ADDR_CNT);
      chk(rd, 32'h3);
      wr(ADDR_CTRL, {8'ha5, 5'h03, p[2:0]});
    end
    wr(ADDR_CTRL, 16'ha518);
    $display("prescale done");
    for (int i = 0; i < 3; i++) begin
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      wr(ADDR_RST, {8'h5a, rc[i]});
      wr(ADDR_CTRL, 16'ha578);
      repeat (3) begin
        cyc(300);
        wr(ADDR_CNT, 16'h5a00);
      end
      chk(overflow_out_n, 1'b1);
      wfor(0, 700);
      cyc(600);
      chk(ovf_len, 128);
      chk(rst_len, rl[i]);
      chk(saw_manual, i == 0);
      rdr(ADDR_RST);
      chk(rd, {24'h0, rc[i] | 8'h80});
      rdr(ADDR_CTRL);
      chk(rd, 32'h18);
      wr(ADDR_RST, 16'ha500);
      rdr(ADDR_RST);
      chk(rd, {24'h0, rc[i]});
    end
    $display("watchdog mode done");
    wr(ADDR_CTRL, 16'ha538);
    wr(ADDR_SBY, 16'h0001);
    chk(standby_active, 1'b0);
    wr(ADDR_CTRL, 16'ha518);
    wr(ADDR_SBY, 16'h0001);
    chk(standby_active, 1'b1);
    wake_req <= 1'b1;
    wfor(2, 700);
    wake_req <= 1'b0;
    rdr(ADDR_SBY);
    chk(rd, 32'h0);
    $display("standby done");
    wr(ADDR_RST, 16'h5a7f);
    wr(ADDR_CTRL, 16'ha578);
    wfor(0, 700);
    cyc(10);
    aresetn <= 1'b0;
    cyc(20);
    aresetn <= 1'b1;
    chk(overflow_out_n, 1'b1);
    rdr(ADDR_RST);
    chk(rd, 32'h1f);
    $display("pin reset done");
    print_verdict();
  end
endmodule
`default_nettype wire

// *** wdt_checker.sv ***
/*
  wdt_checker: port-level checks on wdt_top.
  Assumes it sees only the top module's ports, bound in below.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic overflow_out_n,
  input wire logic chip_reset,
  input wire logic chip_reset_manual,
  input wire logic interval_irq
);
  logic [9:0] lo_q;
  logic [9:0] cr_q;
  // ****
  // pulse width counters
  // ****
  // counters run per cycle, so a long pulse needs no repetition operator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_q <= 10'h000;
      cr_q <= 10'h000;
    end else begin
      lo_q <= overflow_out_n ? 10'h000 : lo_q + 10'h001;
      cr_q <= chip_reset ? cr_q + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // properties
  // ****
  property p_ovf_len;
    $rose(overflow_out_n) |-> lo_q == 10'h080;
  endproperty
  a_ovf_len: assert property (p_ovf_len)
    else $error("overflow pulse length wrong");
  property p_ovf_max;
    lo_q <= 10'h080;
  endproperty
  a_ovf_max: assert property (p_ovf_max)
    else $error("overflow pulse too long");
  property p_rst_len;
    $fell(chip_reset) |-> cr_q == 10'h200;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("chip reset length wrong");
  property p_rst_max;
    cr_q <= 10'h200;
  endproperty
  a_rst_max: assert property (p_rst_max)
    else $error("chip reset too long");
  property p_rst_start;
    $rose(chip_reset) |-> $fell(overflow_out_n);
  endproperty
  a_rst_start: assert property (p_rst_start)
    else $error("chip reset not with overflow pin");
  property p_manual;
    chip_reset_manual |-> chip_reset;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual type without chip reset");
  property p_w_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_resp: assert property (p_w_resp)
    else $error("write response late");
  property p_r_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_resp: assert property (p_r_resp)
    else $error("read response late");
  c_ovf: cover property ($fell(overflow_out_n));
  c_man: cover property ($rose(chip_reset_manual));
  c_irq: cover property ($rose(interval_irq));
endmodule
bind wdt_top wdt_checker u_chk (.*);
`default_nettype wire

// *** wdt_pkg.sv ***
/*
  wdt_pkg: constants for the watchdog and interval timer block.
  Assumes an AXI4-Lite register bus and a 100 MHz system clock.
*/
`default_nettype none
package wdt_pkg;
  // ****************************************
  // register map (byte addresses, 32-bit words)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;   // timer_ctrl_status, 16-bit keyed write
  localparam logic [3:0] ADDR_CNT = 4'h4;    // tick_counter, 16-bit keyed write
  localparam logic [3:0] ADDR_RST = 4'h8;    // reset_ctrl_status, 16-bit keyed write
  localparam logic [3:0] ADDR_SBY = 4'hc;    // standby control/status
  localparam logic [7:0] KEY_CNT = 8'h5a;
  localparam logic [7:0] KEY_CTRL = 8'ha5;
  localparam logic [7:0] KEY_RST_FIELDS = 8'h5a;
  localparam logic [7:0] KEY_RST_CLEAR = 8'ha5;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_OVF = 7;
  localparam int BIT_MODE = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_WATCHDOG_OVERFLOW_FLAG = 7;
  localparam int BIT_CHIP_RESET_ENABLE = 6;
  localparam int BIT_RESET_TYPE_SELECT = 5;
  localparam int BIT_SBY_REQ = 0;
  // ****************************************
  // reset values and read-as-one masks
  // ****************************************
  localparam logic [7:0] CTRL_ONES = 8'h18;
  localparam logic [7:0] RST_ONES = 8'h1f;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [12:0] DIV_RESET = 13'h0000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int OVF_OUT_CYCLES = 128;
  localparam int CHIP_RST_CYCLES = 512;
  localparam logic [9:0] OVF_OUT_CNT = 10'(OVF_OUT_CYCLES);
  localparam logic [9:0] CHIP_RST_CNT = 10'(CHIP_RST_CYCLES);
  localparam logic [9:0] PULSE_ZERO = 10'h000;
  // ****************************************
  // bus response codes
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** wdt_prescaler.sv ***
/*
  wdt_prescaler: gated divider producing one-cycle count pulses, held at zero while run is low.
  Assumes select is stable while counting is enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] select,
  output logic tick
);
  // ****************************************
  // divider state
  // ****************************************
  typedef struct packed {
    logic [12:0] div;
    logic tick;
  } wdt_pre_s;
  wdt_pre_s s_q, s_d;

  // divide ratio minus one per select code
  function automatic logic [12:0] wdt_last(input logic [2:0] sel);
    unique case (sel)
      3'h0: wdt_last = 13'h0001;
      3'h1: wdt_last = 13'h003f;
      3'h2: wdt_last = 13'h007f;
      3'h3: wdt_last = 13'h00ff;
      3'h4: wdt_last = 13'h01ff;
      3'h5: wdt_last = 13'h03ff;
      3'h6: wdt_last = 13'h0fff;
      3'h7: wdt_last = 13'h1fff;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.div = DIV_RESET;  // restart phase so the first interval is full
    end else if (s_q.div >= wdt_last(select)) begin
      s_d.div = DIV_RESET;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 13'h0001;
    end
  end

  // register the divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule
`default_nettype wire

// *** wdt_sys_model.sv ***
/*
  wdt_sys_model: system reset circuit and wake source beside the timer.
  Assumes the bench pulses clr before each measured overflow.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic wake_req,
  input wire logic overflow_out_n,
  input wire logic chip_reset,
  input wire logic chip_reset_manual,
  input wire logic standby_active,
  output logic wake_nmi,
  output logic [9:0] ovf_len,
  output logic [9:0] rst_len,
  output logic saw_manual
);
  logic [9:0] lo = 10'h000;
  logic [9:0] hi = 10'h000;
  always @(posedge aclk) begin
    lo <= overflow_out_n ? 10'h000 : lo + 10'h001;
    hi <= chip_reset ? hi + 10'h001 : 10'h000;
    if (clr) begin
      ovf_len <= 10'h000;
      rst_len <= 10'h000;
      saw_manual <= 1'b0;
    end else begin
      if (overflow_out_n && lo != 10'h000) ovf_len <= lo;
      if (!chip_reset && hi != 10'h000) rst_len <= hi;
      if (chip_reset_manual) saw_manual <= 1'b1;
    end
  end
  // wake level held only while standby lasts
  assign wake_nmi = wake_req && standby_active;
endmodule
`default_nettype wire

// *** wdt_top.sv ***
/*
  wdt_top: eight-bit watchdog / interval timer with AXI4-Lite registers,
  overflow pin, internal chip reset request and standby recovery timing.
  Assumes aresetn is the external reset pin already synchronised, and that
  the chip's clock/power control consumes standby_active and chip_reset.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wake_nmi,
  output logic overflow_out_n,
  output logic chip_reset,
  output logic chip_reset_manual,
  output logic interval_irq,
  output logic standby_active
);
  // ****************************************
  // state
  // ****************************************
  // power states: running, standby, and the recovery count after a wake
  typedef enum logic [2:0] {
    WDT_RUN = 3'b001,
    WDT_SLEEP = 3'b010,
    WDT_WAKE = 3'b100
  } wdt_pwr_e;

  // all block state in one packed struct, filled by one process, registered by another
  typedef struct packed {
    logic awv;
    logic [3:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] tick_counter;
    logic interval_overflow_flag;
    logic mode_select_bit;
    logic count_enable_bit;
    logic [2:0] prescale_select;
    logic watchdog_overflow_flag;
    logic chip_reset_enable;
    logic reset_type_select;
    logic [9:0] ovf_cnt;
    logic [9:0] rst_cnt;
    logic ovf_n;
    logic chip_rst;
    logic rst_manual;
    logic irq;
    logic wake_s1;
    logic wake_s2;
    wdt_pwr_e pwr;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic sby;
  } wdt_s;
  wdt_s s_q, s_d;

  logic tick;
  // recovery timing reuses the prescaler, so no second divider is needed
  logic wake_run;
  assign wake_run = s_q.count_enable_bit || (s_q.pwr == WDT_WAKE);

  // prescaler runs in normal counting and during standby recovery
  wdt_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(wake_run),
    .select(s_q.prescale_select),
    .tick(tick)
  );

  // keyed 16-bit write: both low lanes enabled and key in the high byte
  // a byte store or a wrong key is refused, so a stray write cannot feed the dog
  function automatic logic wdt_keyed(input logic [3:0] ws, input logic [31:0] wd,
                                     input logic [7:0] key);
    wdt_keyed = (ws[1:0] == 2'b11) && (wd[15:8] == key);
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic do_wr;
    logic cnt_wr;
    logic ovf;
    logic wr_ok;
    logic [7:0] rd8;
    do_wr = 1'b0;
    cnt_wr = 1'b0;
    ovf = 1'b0;
    wr_ok = 1'b0;
    rd8 = 8'h00;
    s_d = s_q;
    // wake input from another domain: two flops, only s2 is read
    s_d.wake_s1 = wake_nmi;
    s_d.wake_s2 = s_q.wake_s1;

    // address and data captured independently, in either order
    if (s_axi_awvalid && !s_q.awv) begin
      s_d.awv = 1'b1;
      s_d.awa = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && !s_q.wv) begin
      s_d.wv = 1'b1;
      s_d.wd = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // executes once both halves are held and the last response has been taken
    do_wr = s_q.awv && s_q.wv && !s_q.bvalid;

    // count pulse, dropped when a counter write lands the same cycle
    // write beats increment
    cnt_wr = do_wr && (s_q.awa == ADDR_CNT) && wdt_keyed(s_q.ws, s_q.wd, KEY_CNT);
    if ((s_q.count_enable_bit || s_q.pwr == WDT_WAKE) && tick && !cnt_wr) begin
      ovf = (s_q.tick_counter == 8'hff);
      s_d.tick_counter = s_q.tick_counter + 8'h01;
    end

    // pulse counters for the overflow pin and internal reset
    // a fresh watchdog overflow reloads the pin count, and the reset count if chip reset is enabled, restarting rather than stretching a pulse
    if (s_q.ovf_cnt != PULSE_ZERO) begin
      s_d.ovf_cnt = s_q.ovf_cnt - 10'h001;
    end
    if (s_q.rst_cnt != PULSE_ZERO) begin
      s_d.rst_cnt = s_q.rst_cnt - 10'h001;
    end

    if (ovf && s_q.pwr == WDT_WAKE) begin
      s_d.pwr = WDT_RUN;
      s_d.tick_counter = 8'h00;
    end else if (ovf && s_q.mode_select_bit) begin
      s_d.ovf_cnt = OVF_OUT_CNT;
      s_d.watchdog_overflow_flag = 1'b1;
      if (s_q.chip_reset_enable) begin
        s_d.rst_cnt = CHIP_RST_CNT;
      end
      // counter and control cleared
      // the timer stops here; software must re-arm it after the overflow
      s_d.tick_counter = 8'h00;
      s_d.mode_select_bit = 1'b0;
      s_d.count_enable_bit = 1'b0;
      s_d.prescale_select = PRESCALE_RESET;
      s_d.interval_overflow_flag = 1'b0;
    end else if (ovf) begin
      // interval flag set
      // counting goes on, so interrupts repeat at the chosen period
      s_d.interval_overflow_flag = 1'b1;
    end

    // register writes; hardware set above is kept over a clear here
    if (do_wr) begin
      s_d.awv = 1'b0;
      s_d.wv = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awa)
        ADDR_CTRL: begin
          wr_ok = wdt_keyed(s_q.ws, s_q.wd, KEY_CTRL);
          if (wr_ok && !(ovf && s_q.mode_select_bit)) begin
            s_d.mode_select_bit = s_q.wd[BIT_MODE];
            s_d.count_enable_bit = s_q.wd[BIT_EN];
            s_d.prescale_select = s_q.wd[2:0];
            if (!s_q.wd[BIT_OVF] && !ovf) begin
              s_d.interval_overflow_flag = 1'b0;
            end
          end
        end
        ADDR_CNT: begin
          wr_ok = cnt_wr;
          if (cnt_wr) begin
            s_d.tick_counter = s_q.wd[7:0];
          end
        end
        ADDR_RST: begin
          wr_ok = wdt_keyed(s_q.ws, s_q.wd, KEY_RST_FIELDS) ||
                  wdt_keyed(s_q.ws, s_q.wd, KEY_RST_CLEAR);
          if (wdt_keyed(s_q.ws, s_q.wd, KEY_RST_FIELDS)) begin
            s_d.chip_reset_enable = s_q.wd[BIT_CHIP_RESET_ENABLE];
            s_d.reset_type_select = s_q.wd[BIT_RESET_TYPE_SELECT];
          end else if (wdt_keyed(s_q.ws, s_q.wd, KEY_RST_CLEAR) &&
                       s_q.wd[7:0] == 8'h00 && !(ovf && s_q.mode_select_bit)) begin
            s_d.watchdog_overflow_flag = 1'b0;
          end
        end
        ADDR_SBY: begin
          wr_ok = s_q.ws[0];
          // standby refused while enabled
          // a refused request is still answered OKAY; software reads the status back
          if (s_q.ws[0] && s_q.wd[BIT_SBY_REQ] && !s_q.count_enable_bit &&
              s_q.pwr == WDT_RUN) begin
            s_d.pwr = WDT_SLEEP;
          end
        end
        default: wr_ok = 1'b0;
      endcase
      if (!wr_ok) begin
        s_d.bresp = RESP_SLVERR;
      end
    end

    if (!s_d.count_enable_bit && s_d.pwr != WDT_WAKE) begin
      s_d.tick_counter = 8'h00;
    end

    if (s_q.pwr == WDT_SLEEP && s_q.wake_s2) begin
      s_d.pwr = WDT_WAKE;
      s_d.tick_counter = 8'h00;
    end

    // reads: byte value in the low bits, reserved bits read one except in the standby register, where they read zero
    // limitation: only the low address nibble decodes, so offsets alias every 16 bytes
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      unique case (s_axi_araddr[3:0])
        ADDR_CTRL: rd8 = CTRL_ONES | {s_q.interval_overflow_flag, s_q.mode_select_bit,
                                      s_q.count_enable_bit, 2'b00, s_q.prescale_select};
        ADDR_CNT: rd8 = s_q.tick_counter;
        ADDR_RST: rd8 = RST_ONES | {s_q.watchdog_overflow_flag, s_q.chip_reset_enable,
                                    s_q.reset_type_select, 5'h00};
        ADDR_SBY: rd8 = {7'h00, s_q.pwr != WDT_RUN};
        default: begin
          // unmapped offset: zero data and an error response
          rd8 = 8'h00;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
      s_d.rdata = {24'h000000, rd8};
    end

    // outputs registered from the counters
    s_d.ovf_n = (s_d.ovf_cnt == PULSE_ZERO);
    s_d.chip_rst = (s_d.rst_cnt != PULSE_ZERO);
    s_d.rst_manual = (s_d.rst_cnt != PULSE_ZERO) && s_d.reset_type_select;
    // the interrupt follows the flag only while in interval mode
    s_d.irq = s_d.interval_overflow_flag && !s_d.mode_select_bit;
    // ready and status pins are flops too, so no output passes through a gate
    s_d.awrdy = !s_d.awv;
    s_d.wrdy = !s_d.wv;
    s_d.arrdy = !s_d.rvalid;
    s_d.sby = (s_d.pwr != WDT_RUN);
  end

  // ****************************************
  // state register
  // ****************************************
  // pin reset wins and clears the watchdog flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ovf_n <= 1'b1;
      s_q.reset_type_select <= 1'b0;
      s_q.prescale_select <= PRESCALE_RESET;
      s_q.pwr <= WDT_RUN;
      // readys rise in reset so the bus idles in the accepting state
      s_q.awrdy <= 1'b1;
      s_q.wrdy <= 1'b1;
      s_q.arrdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs straight from flops
  // ****************************************
  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready = s_q.wrdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign overflow_out_n = s_q.ovf_n;
  assign chip_reset = s_q.chip_rst;
  assign chip_reset_manual = s_q.rst_manual;
  assign interval_irq = s_q.irq;
  assign standby_active = s_q.sby;
endmodule
`default_nettype wire
